// file: hw/opmod_map.vh
// constants for the operand and result conditioning stage
// assumes fixed point components, 12 bits, 8 fraction bits
`ifndef OPMOD_MAP_VH
`define OPMOD_MAP_VH

`define COMP_W          12
`define FRAC_W          8
`define VEC_W           48
`define FIX_ONE         12'h100
`define FIX_HALF        12'h080
`define FIX_ZERO        12'h000
`define FIX_MAX         12'h7ff
`define FIX_MIN         12'h800

// channel selector codes
`define SEL_NONE        3'h0
`define SEL_RED         3'h1
`define SEL_GREEN       3'h2
`define SEL_BLUE        3'h3
`define SEL_ALPHA       3'h4

// result scale codes
`define SCL_NONE        3'h0
`define SCL_X2          3'h1
`define SCL_X4          3'h2
`define SCL_X8          3'h3
`define SCL_D2          3'h4
`define SCL_D4          3'h5
`define SCL_D8          3'h6

// version codes
`define VER_10          3'h0
`define VER_11          3'h1
`define VER_12          3'h2
`define VER_13          3'h3
`define VER_14          3'h4

`endif

// file: hw/operand_cond.v
// one operand path: channel replicate, then source modifiers
// assumes a registered operand from the register file; pure logic
`timescale 1ns/1ps
`include "opmod_map.vh"

module operand_cond (
    input  wire [`VEC_W-1:0] opnd_i,
    input  wire [2:0]        sel_i,
    input  wire              bias_i,
    input  wire              signed_expand_i,
    input  wire              times_two_i,
    input  wire              complement_i,
    input  wire              negate_i,
    output reg  [`VEC_W-1:0] opnd_o
);

    // ************************************************************
    // saturating component arithmetic
    // ************************************************************
    function [`COMP_W-1:0] sat_fix;
        input signed [`COMP_W+1:0] v;
        begin
            if (v > $signed({3'h0, 11'h7ff}))
                sat_fix = `FIX_MAX;
            else if (v < $signed({3'h7, 11'h000}))
                sat_fix = `FIX_MIN;
            else
                sat_fix = v[`COMP_W-1:0];
        end
    endfunction

    reg [`COMP_W-1:0]          comp;
    reg [`COMP_W-1:0]          repl;
    reg signed [`COMP_W+1:0]   wide;
    integer                    k;

    always @* begin
        opnd_o = {`VEC_W{1'b0}};
        comp   = `FIX_ZERO;
        wide   = 14'sh0;
        // channel 0 red, 3 alpha
        case (sel_i) // RULE13 RULE15
            `SEL_RED:   repl = opnd_i[11:0];
            `SEL_GREEN: repl = opnd_i[23:12];
            `SEL_BLUE:  repl = opnd_i[35:24];
            `SEL_ALPHA: repl = opnd_i[47:36];
            default:    repl = `FIX_ZERO;
        endcase
        for (k = 0; k < 4; k = k + 1) begin
            if (sel_i == `SEL_NONE)
                comp = opnd_i[k*12 +: 12];
            else
                comp = repl; // RULE13
            wide = {{2{comp[11]}}, comp};
            if (complement_i) begin
                // complement stands alone
                wide = $signed({2'h0, `FIX_ONE}) - wide; // RULE17
            end else begin
                if (bias_i || signed_expand_i)
                    wide = wide - $signed({2'h0, `FIX_HALF}); // RULE16
                if (signed_expand_i || times_two_i)
                    wide = wide <<< 1; // RULE16
                if (negate_i)
                    wide = -wide; // RULE10 RULE17
            end
            opnd_o[k*12 +: 12] = sat_fix(wide); // RULE7
        end
    end

endmodule

// file: hw/shader_operand_result_modifiers.v
// operand and result conditioning stage of a pixel shading unit
// assumes operand controls and operands valid with VALID_I, result controls and results with RES_VALID_I, one clock
//
// What the document requires
// RULE1 - scale and clamp result after operation, before destination write
// RULE2 - multiply options scale result by two, four or eight
// RULE3 - divide options scale result by half, quarter or eighth
// RULE4 - saturate clamps every component into zero to one
// RULE5 - scaling happens first, then the clamp
// RULE6 - issuer puts result options only on arithmetic operations
// RULE7 - source modifiers change delivered operand only, not stored register
// RULE8 - issuer uses source modifiers on arithmetic, signed expand exceptions
// RULE9 - signed expand allowed on texture sources per version
// RULE10 - negate applies last after bias, signed expand or doubling
// RULE11 - issuer never combines complement with another source modifier
// RULE12 - modifiers on constants undefined; version 1.4 rejects them
// RULE13 - channel selector replicates one channel into all four
// RULE14 - blue replicate in 1.1 to 1.3 only with alpha-only write; this block does not check it
// RULE15 - selector applied before source modifiers; any combination allowed
// RULE16 - bias subtracts half; signed expand subtracts half then doubles
// RULE17 - complement gives one minus value; negate gives negative
`timescale 1ns/1ps
`include "opmod_map.vh"

module shader_operand_result_modifiers (
    input  wire              REF_CLK_I,
    input  wire              RST_B_I,
    input  wire              VALID_I,
    input  wire [2:0]        VERSION_I,
    input  wire              TEX_OP_I,
    input  wire              TEX_MATRIX_I,
    input  wire              SRC_CONST_I,
    input  wire [`VEC_W-1:0] OPND_I,
    input  wire [2:0]        SEL_I,
    input  wire              BIAS_I,
    input  wire              SIGNED_EXPAND_I,
    input  wire              TIMES_TWO_I,
    input  wire              COMPLEMENT_I,
    input  wire              NEGATE_I,
    input  wire              RES_VALID_I,
    input  wire [`VEC_W-1:0] RES_I,
    input  wire [2:0]        RES_SCALE_I,
    input  wire              SAT_I,
    output reg               OPND_VALID_O,
    output reg  [`VEC_W-1:0] OPND_O,
    output reg               OPND_REJECT_O,
    output reg               WR_VALID_O,
    output reg  [`VEC_W-1:0] WR_DATA_O
);

    // ************************************************************
    // operand side
    // ************************************************************
    wire [`VEC_W-1:0] cond_opnd;
    wire              any_mod;
    reg               reject;

    operand_cond u_operand_cond (
        .opnd_i          (OPND_I),
        .sel_i           (SEL_I),
        .bias_i          (BIAS_I),
        .signed_expand_i (SIGNED_EXPAND_I),
        .times_two_i     (TIMES_TWO_I),
        .complement_i    (COMPLEMENT_I),
        .negate_i        (NEGATE_I),
        .opnd_o          (cond_opnd)
    );

    assign any_mod = BIAS_I | SIGNED_EXPAND_I | TIMES_TWO_I |
                     COMPLEMENT_I | NEGATE_I;

    always @* begin
        reject = 1'b0;
        if (SRC_CONST_I && any_mod && VERSION_I == `VER_14)
            reject = 1'b1; // RULE12
        if (TEX_OP_I && SIGNED_EXPAND_I) begin
            if (VERSION_I == `VER_10 || VERSION_I == `VER_11)
                reject = reject | ~TEX_MATRIX_I; // RULE9
            else if (VERSION_I == `VER_14)
                reject = 1'b1; // RULE9
        end
    end

    always @(posedge REF_CLK_I) begin
        if (!RST_B_I) begin
            OPND_VALID_O  <= 1'b0;
            OPND_REJECT_O <= 1'b0;
            OPND_O        <= {`VEC_W{1'b0}};
        end else begin
            OPND_VALID_O  <= VALID_I & ~reject;
            OPND_REJECT_O <= VALID_I & reject; // RULE12
            if (VALID_I && !reject)
                OPND_O <= cond_opnd; // RULE7 RULE15
        end
    end

    // ************************************************************
    // result side
    // ************************************************************
    function [`COMP_W-1:0] scale_fix;
        input [`COMP_W-1:0] v;
        input [2:0]         s;
        reg signed [`COMP_W+3:0] w;
        begin
            w = {{4{v[11]}}, v};
            case (s)
                `SCL_X2: w = w <<< 1; // RULE2
                `SCL_X4: w = w <<< 2; // RULE2
                `SCL_X8: w = w <<< 3; // RULE2
                `SCL_D2: w = w >>> 1; // RULE3
                `SCL_D4: w = w >>> 2; // RULE3
                `SCL_D8: w = w >>> 3; // RULE3
                default: w = w;
            endcase
            if (w > $signed({5'h00, 11'h7ff}))
                scale_fix = `FIX_MAX;
            else if (w < $signed({5'h1f, 11'h000}))
                scale_fix = `FIX_MIN;
            else
                scale_fix = w[`COMP_W-1:0];
        end
    endfunction

    function [`COMP_W-1:0] clamp_unit;
        input [`COMP_W-1:0] v;
        begin
            if (v[11])
                clamp_unit = `FIX_ZERO; // RULE4
            else if (v > `FIX_ONE)
                clamp_unit = `FIX_ONE; // RULE4
            else
                clamp_unit = v;
        end
    endfunction

    reg [`VEC_W-1:0]  res_next;
    reg [`COMP_W-1:0] scaled;
    integer           j;

    always @* begin
        res_next = {`VEC_W{1'b0}};
        scaled   = `FIX_ZERO;
        for (j = 0; j < 4; j = j + 1) begin
            scaled = scale_fix(RES_I[j*12 +: 12], RES_SCALE_I); // RULE1
            if (SAT_I)
                scaled = clamp_unit(scaled); // RULE5
            res_next[j*12 +: 12] = scaled;
        end
    end

    always @(posedge REF_CLK_I) begin
        if (!RST_B_I) begin
            WR_VALID_O <= 1'b0;
            WR_DATA_O  <= {`VEC_W{1'b0}};
        end else begin
            WR_VALID_O <= RES_VALID_I; // RULE1
            if (RES_VALID_I)
                WR_DATA_O <= res_next; // RULE1
        end
    end

endmodule

// file: dv/dec_model.sv
// decoder model: issues operand and result requests
// assumes the caller packs controls as the test top wires them
`timescale 1ns/1ps
module dec_model (
    input  wire         clk_i,
    output reg  [115:0] ctl_o
);
    // ************************
    // request issue
    // ************************
    initial ctl_o = 116'h0;
    task issue(input [115:0] c);
        begin
            @(posedge clk_i) ctl_o <= c;
            @(posedge clk_i) begin
                ctl_o[115] <= 1'b0;
                ctl_o[52]  <= 1'b0;
            end
        end
    endtask
endmodule

// file: dv/sorm_checker.sv
// assertions on the conditioning stage ports
// assumes bind to the top module, one clock, sync low reset
`timescale 1ns/1ps
`include "opmod_map.vh"
module sorm_checker (
    input wire              REF_CLK_I, RST_B_I, VALID_I, SRC_CONST_I,
    input wire              BIAS_I, RES_VALID_I, SAT_I,
    input wire [2:0]        VERSION_I, RES_SCALE_I,
    input wire [`VEC_W-1:0] RES_I, OPND_O, WR_DATA_O,
    input wire              OPND_VALID_O, OPND_REJECT_O, WR_VALID_O
);
    // ************************
    // properties
    // ************************
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    function automatic bit in01(input [`VEC_W-1:0] v);
        in01 = 1'b1;
        for (int k = 0; k < 4; k++)
            if (v[12*k+11] || v[12*k+:12] > `FIX_ONE) in01 = 1'b0;
    endfunction
    sequence s_const_req;
        VALID_I && SRC_CONST_I && BIAS_I && VERSION_I == `VER_14;
    endsequence
    sequence s_refused;
        OPND_REJECT_O && !OPND_VALID_O;
    endsequence
    chk_const_refused: assert property (
        s_const_req |=> s_refused)
        else $error("constant operand not refused");
    chk_opnd_answer: assert property (
        VALID_I |=> OPND_VALID_O != OPND_REJECT_O)
        else $error("operand request unanswered");
    chk_opnd_quiet: assert property (
        !VALID_I |=> !OPND_VALID_O && !OPND_REJECT_O)
        else $error("operand answer without request");
    chk_wr_answer: assert property (RES_VALID_I |=> WR_VALID_O)
        else $error("result write missing");
    chk_wr_quiet: assert property (!RES_VALID_I |=> !WR_VALID_O)
        else $error("result write without request");
    chk_sat_range: assert property (
        WR_VALID_O && $past(SAT_I) |-> in01(WR_DATA_O))
        else $error("saturated result out of range");
    chk_wr_hold: assert property (!WR_VALID_O |-> $stable(WR_DATA_O))
        else $error("write data moved");
    chk_opnd_hold: assert property (!OPND_VALID_O |-> $stable(OPND_O))
        else $error("operand moved without valid");
    chk_double_res: assert property (
        RES_VALID_I && RES_SCALE_I == `SCL_X2 && !SAT_I &&
        RES_I[11:10] == 2'h0
        |=> WR_DATA_O[11:1] == $past(RES_I[10:0]))
        else $error("doubled result wrong");
    chk_halve_res: assert property (
        RES_VALID_I && RES_SCALE_I == `SCL_D2 && !SAT_I
        |=> WR_DATA_O[10:0] == $past(RES_I[11:1]))
        else $error("halved result wrong");
endmodule

// file: dv/shader_operand_result_modifiers_test.sv
// self-checking bench for the operand and result conditioning stage
// assumes the decoder model drives every control input except the reset, which the bench drives
`timescale 1ns/1ps
`include "opmod_map.vh"
module shader_operand_result_modifiers_test;
    // ************************
    // clock, wiring, checks
    // ************************
    localparam [47:0] BASE = 48'h1000c0080040;
    reg          ref_clk;
    reg          rst_b;
    wire [115:0] ctl;
    wire         opnd_valid, opnd_reject, wr_valid;
    wire [47:0]  opnd, wr_data;
    integer      num_errors, checks, i;
    typedef struct packed {logic [2:0] sel; logic [4:0] md;
        logic [11:0] res; logic [2:0] scl; logic sat;
        logic [47:0] eop; logic [11:0] ewr;} row_t;
    row_t        rows [0:6];
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    dec_model u_dec (.clk_i(ref_clk), .ctl_o(ctl));
    shader_operand_result_modifiers uut (
        .REF_CLK_I(ref_clk), .RST_B_I(rst_b), .VALID_I(ctl[115]),
        .VERSION_I(ctl[114:112]), .TEX_OP_I(ctl[111]),
        .TEX_MATRIX_I(ctl[110]), .SRC_CONST_I(ctl[109]),
        .OPND_I(ctl[108:61]), .SEL_I(ctl[60:58]), .BIAS_I(ctl[57]),
        .SIGNED_EXPAND_I(ctl[56]), .TIMES_TWO_I(ctl[55]),
        .COMPLEMENT_I(ctl[54]), .NEGATE_I(ctl[53]),
        .RES_VALID_I(ctl[52]), .RES_I(ctl[51:4]),
        .RES_SCALE_I(ctl[3:1]), .SAT_I(ctl[0]), .OPND_VALID_O(opnd_valid),
        .OPND_O(opnd), .OPND_REJECT_O(opnd_reject),
        .WR_VALID_O(wr_valid), .WR_DATA_O(wr_data));
    function [115:0] mk(input [2:0] ver, input [2:0] fl, input [2:0] sel,
        input [4:0] md, input [11:0] res, input [2:0] scl, input sat);
        mk = {1'b1, ver, fl, BASE, sel, md, 1'b1, {4{res}}, scl, sat};
    endfunction
    task chk(input [47:0] seen, input [47:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task run(input [115:0] c);
        begin
            u_dec.issue(c);
            #1;
        end
    endtask
    task stop_test;
        begin
            $display("checks=%0d errors=%0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #5000;
        num_errors = num_errors + 1;
        stop_test;
    end
    // ************************
    // tests
    // ************************
    initial begin
        num_errors = 0;
        checks = 0;
        rst_b = 1'b0;
        rows[0] = '{3'h1, 5'h00, 12'h060, 3'h1, 1'b0, {4{12'h040}}, 12'h0c0};
        rows[1] = '{3'h2, 5'h10, 12'h060, 3'h2, 1'b1, 48'h0, 12'h100};
        rows[2] = '{3'h3, 5'h08, 12'h060, 3'h3, 1'b0, {4{12'h080}}, 12'h300};
        rows[3] = '{3'h4, 5'h02, 12'h060, 3'h4, 1'b0, 48'h0, 12'h030};
        rows[4] = '{3'h0, 5'h01, 12'h060, 3'h5, 1'b0, 48'hf00f40f80fc0, 12'h018};
        rows[5] = '{3'h1, 5'h11, 12'h060, 3'h6, 1'b0, {4{12'h040}}, 12'h00c};
        rows[6] = '{3'h2, 5'h05, 12'hf00, 3'h0, 1'b1, {4{12'hf00}}, 12'h000};
        repeat (2) @(posedge ref_clk);
        #1;
        chk({opnd_valid, opnd_reject, wr_valid}, 3'h0);
        chk(opnd | wr_data, 48'h0);
        @(posedge ref_clk) rst_b <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            run(mk(`VER_14, 3'h0, rows[i].sel, rows[i].md, rows[i].res,
                rows[i].scl, rows[i].sat));
            chk(opnd, rows[i].eop);
            chk(wr_data, {4{rows[i].ewr}});
            chk({opnd_valid, wr_valid}, 2'h3);
            $display("test %0d done", i);
        end
        run(mk(`VER_14, 3'h1, 3'h1, 5'h10, 12'h060, 3'h0, 1'b0));
        chk({opnd_reject, opnd_valid}, 2'h2);
        chk(opnd, {4{12'hf00}});
        run(mk(`VER_11, 3'h4, 3'h3, 5'h08, 12'h060, 3'h0, 1'b0));
        chk({opnd_reject, opnd_valid}, 2'h2);
        run(mk(`VER_11, 3'h6, 3'h3, 5'h08, 12'h060, 3'h0, 1'b0));
        chk(opnd, {4{12'h080}});
        run(mk(`VER_13, 3'h4, 3'h4, 5'h08, 12'h060, 3'h0, 1'b0));
        chk({opnd_reject, opnd_valid}, 2'h1);
        chk(opnd, {4{12'h100}});
        $display("refusal tests done");
        stop_test;
    end
endmodule
bind shader_operand_result_modifiers sorm_checker u_chk (
    .REF_CLK_I, .RST_B_I, .VALID_I, .SRC_CONST_I, .BIAS_I, .RES_VALID_I,
    .SAT_I, .VERSION_I, .RES_SCALE_I, .RES_I, .OPND_O, .WR_DATA_O,
    .OPND_VALID_O, .OPND_REJECT_O, .WR_VALID_O);
